// *** logic/mspeed_pkg.sv ***
`default_nettype none
package mspeed_pkg;
	// ----------------------------------------
	// frequency format: unsigned, 0.1 Hz per lsb
	// ----------------------------------------
	localparam int          FREQ_W          = 16;
	localparam int          CODE_W          = 8;
	localparam int          SEL_W           = 4;
	localparam int          NUM_SPEEDS      = 16;
	localparam int          NUM_TERMS       = 5;
	localparam logic [15:0] FREQ_RESET      = 16'h0000;
	localparam logic [15:0] JOG_LIMIT       = 16'h0064; // 10.0 Hz
	localparam logic [15:0] FREQ_STEP       = 16'h0001;

	// ----------------------------------------
	// terminal function codes
	// ----------------------------------------
	localparam logic [7:0]  FUNCTION_KEY_SEL_BIT0   = 8'h02;
	localparam logic [7:0]  FUNCTION_KEY_SEL_BIT1   = 8'h03;
	localparam logic [7:0]  FUNCTION_KEY_SEL_BIT2   = 8'h04;
	localparam logic [7:0]  FUNCTION_KEY_SEL_BIT3   = 8'h05;
	localparam logic [7:0]  FUNCTION_KEY_JOG        = 8'h06;

	// ----------------------------------------
	// run source and jog stop selection codes
	// ----------------------------------------
	localparam logic [7:0]  RUN_SRC_TERMINAL = 8'h01;
	localparam logic [7:0]  JOG_STOP_COAST   = 8'h00;
	localparam logic [7:0]  JOG_STOP_DECEL   = 8'h01;
	localparam logic [7:0]  JOG_STOP_DCBRAKE = 8'h02;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int          CLK_PERIOD_NS   = 4;
	localparam int          RAMP_STEP_NS    = 1000000;
	localparam int          RAMP_STEP_CYC   = RAMP_STEP_NS / CLK_PERIOD_NS;
	localparam int          BRAKE_HOLD_NS   = 1000;
	localparam int          BRAKE_HOLD_CYC  = (BRAKE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CNT_W           = 24;

	// ----------------------------------------
	// drive state
	// ----------------------------------------
	typedef enum logic [4:0] {
		ST_STOP      = 5'b00001,
		ST_RUN       = 5'b00010,
		ST_JOG       = 5'b00100,
		ST_JOG_DECEL = 5'b01000,
		ST_JOG_BRAKE = 5'b10000
	} drive_state_t;
endpackage
`default_nettype wire

// *** logic/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync
#(
	parameter int W = 1
)
(
	input  wire logic         clk_sys_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_q;

	// ----------------------------------------
	// two-stage synchroniser for pin levels
	// ----------------------------------------
	// first stage feeds only the second stage
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_q <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule
`default_nettype wire

// *** logic/term_function_key_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module term_function_key_map
	import mspeed_pkg::*;
(
	input  wire logic [NUM_TERMS-1:0]        term_i,
	input  wire logic [NUM_TERMS*CODE_W-1:0] term_function_key_i,
	output logic      [SEL_W-1:0]            speed_sel_o,
	output logic                             jog_input_o
);
	// ----------------------------------------
	// function-code routing of the five terminals
	// ----------------------------------------
	// several terminals with one code are or-ed together
	always_comb
	begin
		logic [CODE_W-1:0] code;
		code        = '0;
		speed_sel_o = '0;
		jog_input_o = 1'b0;
		for (int t = 0; t < NUM_TERMS; t++)
		begin
			code = term_function_key_i[t*CODE_W +: CODE_W];
			if (code == FUNCTION_KEY_SEL_BIT0) speed_sel_o[0] = speed_sel_o[0] | term_i[t];
			if (code == FUNCTION_KEY_SEL_BIT1) speed_sel_o[1] = speed_sel_o[1] | term_i[t];
			if (code == FUNCTION_KEY_SEL_BIT2) speed_sel_o[2] = speed_sel_o[2] | term_i[t];
			if (code == FUNCTION_KEY_SEL_BIT3) speed_sel_o[3] = speed_sel_o[3] | term_i[t];
			if (code == FUNCTION_KEY_JOG)      jog_input_o    = jog_input_o | term_i[t];
		end
	end
endmodule
`default_nettype wire

// *** logic/multispeed_jog_select.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// - four select inputs form binary index, bit0 lsb
// - codes 02-05 select bits, 06 jog
// - functions map only onto five programmable terminals
// - sixteen speed registers indexed by select value
// - nothing committed without store key press
// - terminal programming only with run off
// - store writes selected register, display follows it
// - monitor shows present output frequency always
// - stored speed accepted only within maximum limit
// - jog frequency from parameter, capped 10 Hz
// - jog frequency applied immediately, no ramp
// - jog input plus run drives jog frequency
// - run key jogs only with terminal source
// - jog stop: coast, decelerate, or dc brake
// - no jog below start frequency or zero
// - index zero uses first speed register
// - forward and reverse together means stop
module multispeed_jog_select
	import mspeed_pkg::*;
#(
	parameter int RAMP_CYC = RAMP_STEP_CYC
)
(
	input  wire logic                        clk_sys_i,
	input  wire logic                        rst_i,
	input  wire logic [NUM_TERMS-1:0]        term_pin_i,
	input  wire logic                        fwd_run_pin_i,
	input  wire logic                        rev_run_pin_i,
	input  wire logic [NUM_TERMS*CODE_W-1:0] terminal_function_key_i,
	input  wire logic [CODE_W-1:0]           run_cmd_source_i,
	input  wire logic [FREQ_W-1:0]           jog_frequency_i,
	input  wire logic [CODE_W-1:0]           jog_stop_select_i,
	input  wire logic [FREQ_W-1:0]           max_frequency_limit_i,
	input  wire logic [FREQ_W-1:0]           start_frequency_i,
	input  wire logic                        run_key_i,
	input  wire logic                        up_key_i,
	input  wire logic                        down_key_i,
	input  wire logic                        store_key_i,
	input  wire logic                        param_wr_i,
	input  wire logic [SEL_W-1:0]            param_idx_i,
	input  wire logic [FREQ_W-1:0]           param_data_i,
	output logic      [FREQ_W-1:0]           target_freq_o,
	output logic      [FREQ_W-1:0]           freq_monitor_o,
	output logic      [FREQ_W-1:0]           freq_setting_display_o,
	output logic      [SEL_W-1:0]            speed_sel_o,
	output logic                             running_o,
	output logic                             jogging_o,
	output logic                             coast_o,
	output logic                             dc_brake_o,
	output logic                             store_reject_o
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// limit check shared by keypad and terminal stores
	function automatic logic freq_ok(input logic [FREQ_W-1:0] f, input logic [FREQ_W-1:0] lim);
		freq_ok = (f <= lim);
	endfunction

	// one ramp step of the output towards a goal
	function automatic logic [FREQ_W-1:0] step_to(input logic [FREQ_W-1:0] cur, input logic [FREQ_W-1:0] goal);
		if (cur < goal)
			step_to = cur + FREQ_STEP;
		else if (cur > goal)
			step_to = cur - FREQ_STEP;
		else
			step_to = cur;
	endfunction

	// ----------------------------------------
	// input capture
	// ----------------------------------------
	logic [NUM_TERMS-1:0] term_s;
	logic                 fwd_s;
	logic                 rev_s;
	logic [SEL_W-1:0]     sel_c;
	logic                 jog_c;

	pin_sync #(
		.W (NUM_TERMS + 2)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.async_i   ({term_pin_i, fwd_run_pin_i, rev_run_pin_i}),
		.sync_o    ({term_s, fwd_s, rev_s})
	);

	// only the five programmable terminals carry these functions
	term_function_key_map u_map (
		.term_i      (term_s),
		.term_function_key_i (terminal_function_key_i),
		.speed_sel_o (sel_c),
		.jog_input_o (jog_c)
	);

	// ----------------------------------------
	// run decode
	// ----------------------------------------
	logic                 terminal_src;
	logic                 term_run;
	logic                 run_cmd;
	logic                 jog_run;
	logic [FREQ_W-1:0]    jog_eff;
	logic                 jog_ok;

	assign terminal_src = (run_cmd_source_i == RUN_SRC_TERMINAL);
	// both directions at once is a stop request
	assign term_run     = fwd_s ^ rev_s;
	// keypad run key counts for jog only in terminal mode
	assign run_cmd      = terminal_src ? (term_run | run_key_i) : run_key_i;
	assign jog_run      = jog_c & terminal_src & (term_run | run_key_i);
	// cap at 10 Hz rather than reject, keeps jog usable
	assign jog_eff      = (jog_frequency_i > JOG_LIMIT) ? JOG_LIMIT : jog_frequency_i;
	assign jog_ok       = (jog_eff != FREQ_RESET) && (jog_eff >= start_frequency_i);

	// ----------------------------------------
	// speed register bank
	// ----------------------------------------
	logic [FREQ_W-1:0]    speed_q [NUM_SPEEDS];
	logic [SEL_W-1:0]     sel_q;
	logic [FREQ_W-1:0]    edit_q;
	logic                 dirty_q;
	logic                 term_store;
	logic                 key_store;
	drive_state_t         state_q;
	drive_state_t         state_d;

	// terminal programming needs stop mode and a pending edit
	assign term_store = store_key_i & dirty_q & (state_q == ST_STOP) & ~run_cmd;
	assign key_store  = param_wr_i & store_key_i;

	// select index registered every clock
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			sel_q <= '0;
		else
			sel_q <= sel_c;
	end

	// writes happen only on a store key press
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < NUM_SPEEDS; i++)
				speed_q[i] <= FREQ_RESET;
		end
		else if (term_store && freq_ok(edit_q, max_frequency_limit_i))
			speed_q[sel_q] <= edit_q;
		else if (key_store && freq_ok(param_data_i, max_frequency_limit_i))
			speed_q[param_idx_i] <= param_data_i;
	end

	// displayed setting: follows the selected register until edited
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			edit_q  <= FREQ_RESET;
			dirty_q <= 1'b0;
		end
		else if (term_store)
		begin
			dirty_q <= 1'b0; // display returns to stored value
			edit_q  <= speed_q[sel_q];
		end
		else if (sel_q != sel_c)
		begin
			// new index drops an unstored edit
			dirty_q <= 1'b0;
			edit_q  <= speed_q[sel_c];
		end
		else if (state_q == ST_STOP && !run_cmd && (up_key_i ^ down_key_i))
		begin
			dirty_q <= 1'b1;
			if (up_key_i && edit_q != {FREQ_W{1'b1}})
				edit_q <= edit_q + FREQ_STEP;
			else if (down_key_i && edit_q != FREQ_RESET)
				edit_q <= edit_q - FREQ_STEP;
		end
		else if (!dirty_q)
			edit_q <= speed_q[sel_q];
	end

	// refused stores raise a flag until the next store attempt
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			store_reject_o <= 1'b0;
		else if (term_store)
			store_reject_o <= ~freq_ok(edit_q, max_frequency_limit_i);
		else if (key_store)
			store_reject_o <= ~freq_ok(param_data_i, max_frequency_limit_i);
	end

	// ----------------------------------------
	// drive state machine
	// ----------------------------------------
	logic [CNT_W-1:0]     ramp_cnt_q;
	logic [CNT_W-1:0]     brake_cnt_q;
	logic                 ramp_tick;
	logic [FREQ_W-1:0]    out_q;

	assign ramp_tick = (ramp_cnt_q == CNT_W'(RAMP_CYC - 1));

	// jog ends per stop selection; a running normal drive ramps down
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_STOP:
			begin
				if (jog_run && jog_ok)
					state_d = ST_JOG;
				else if (run_cmd && !jog_c)
					state_d = ST_RUN;
			end
			ST_RUN:
			begin
				if (!run_cmd && out_q == FREQ_RESET)
					state_d = ST_STOP;
			end
			ST_JOG:
			begin
				if (!jog_run || !jog_ok)
				begin
					if (jog_stop_select_i == JOG_STOP_DECEL)
						state_d = ST_JOG_DECEL;
					else if (jog_stop_select_i == JOG_STOP_DCBRAKE)
						state_d = ST_JOG_BRAKE;
					else
						state_d = ST_STOP;
				end
			end
			ST_JOG_DECEL:
			begin
				if (out_q == FREQ_RESET)
					state_d = ST_STOP;
			end
			ST_JOG_BRAKE:
			begin
				if (brake_cnt_q == CNT_W'(BRAKE_HOLD_CYC - 1))
					state_d = ST_STOP;
			end
			default:
				state_d = ST_STOP;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			state_q <= ST_STOP;
		else
			state_q <= state_d;
	end

	// free-running ramp divider
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			ramp_cnt_q <= '0;
		else if (ramp_tick)
			ramp_cnt_q <= '0;
		else
			ramp_cnt_q <= ramp_cnt_q + 1'b1;
	end

	// dc brake hold timer
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			brake_cnt_q <= '0;
		else if (state_q == ST_JOG_BRAKE)
			brake_cnt_q <= brake_cnt_q + 1'b1;
		else
			brake_cnt_q <= '0;
	end

	// ----------------------------------------
	// frequency outputs
	// ----------------------------------------
	// target from the bank outside jog, capped jog setting in jog; index zero reads the first register
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			target_freq_o <= FREQ_RESET;
		else if (state_q == ST_JOG)
			target_freq_o <= jog_eff;
		else
			target_freq_o <= speed_q[sel_q];
	end

	// output frequency: ramped for normal run, stepped for jog
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			out_q <= FREQ_RESET;
		else
		begin
			case (state_q)
				ST_RUN:
				begin
					if (ramp_tick)
						out_q <= step_to(out_q, run_cmd ? target_freq_o : FREQ_RESET);
				end
				ST_JOG:
					out_q <= jog_eff;
				ST_JOG_DECEL:
				begin
					if (ramp_tick)
						out_q <= step_to(out_q, FREQ_RESET);
				end
				default:
					out_q <= FREQ_RESET; // coast and brake drop the output
			endcase
		end
	end

	// monitor mirrors the present output in every segment
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			freq_monitor_o <= FREQ_RESET;
		else
			freq_monitor_o <= out_q;
	end

	// status pins, all registered
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			freq_setting_display_o <= FREQ_RESET;
			speed_sel_o            <= '0;
			running_o              <= 1'b0;
			jogging_o              <= 1'b0;
			coast_o                <= 1'b0;
			dc_brake_o             <= 1'b0;
		end
		else
		begin
			freq_setting_display_o <= edit_q;
			speed_sel_o            <= sel_q;
			running_o              <= (state_q != ST_STOP);
			jogging_o              <= (state_q == ST_JOG);
			coast_o                <= (state_q == ST_JOG) && (state_d == ST_STOP);
			dc_brake_o             <= (state_q == ST_JOG_BRAKE);
		end
	end
endmodule
`default_nettype wire

// *** verif/mspeed_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// switches on the programmable terminals
// ----
module mspeed_partner
	import mspeed_pkg::*;
(
	input  wire logic                        clk_sys_i,
	input  wire logic [SEL_W-1:0]            sel_i,
	input  wire logic                        jog_i,
	input  wire logic                        running_i,
	input  wire logic [NUM_TERMS*CODE_W-1:0] function_key_i,
	output logic      [NUM_TERMS-1:0]        pin_o
);
	logic              jog_q = 1'b0;
	logic [CODE_W-1:0] c;
	// the operator only flips the jog switch with the motor stopped
	always @(posedge clk_sys_i)
		if (running_i !== 1'b1)
			jog_q <= #1 jog_i;
	// each terminal carries whatever function its code names
	always_comb
	begin
		c = '0;
		for (int t = 0; t < NUM_TERMS; t++)
		begin
			c = function_key_i[t*CODE_W+:CODE_W] - FUNCTION_KEY_SEL_BIT0;
			if (c < 8'h04)
				pin_o[t] = sel_i[c[1:0]];
			else
				pin_o[t] = (function_key_i[t*CODE_W+:CODE_W] == FUNCTION_KEY_JOG) && jog_q;
		end
	end
endmodule
`default_nettype wire

// *** verif/multispeed_jog_select_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module multispeed_jog_select_checker
	import mspeed_pkg::*;
(
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	input  wire logic [CODE_W-1:0] run_cmd_source_i,
	input  wire logic [FREQ_W-1:0] jog_frequency_i,
	input  wire logic [CODE_W-1:0] jog_stop_select_i,
	input  wire logic [FREQ_W-1:0] start_frequency_i,
	input  wire logic              store_key_i,
	input  wire logic [FREQ_W-1:0] target_freq_o,
	input  wire logic [FREQ_W-1:0] freq_monitor_o,
	input  wire logic              running_o,
	input  wire logic              jogging_o,
	input  wire logic              coast_o,
	input  wire logic              dc_brake_o,
	input  wire logic              store_reject_o
);
	logic [FREQ_W-1:0] jcap;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// ----
	// jog
	// ----
	// clamp, not refusal, for jog settings above the limit
	assign jcap = (jog_frequency_i > JOG_LIMIT) ? JOG_LIMIT : jog_frequency_i;
	a_jog_capped: assert property (jogging_o |-> target_freq_o == jcap)
		else $error("jog target not the capped setting");
	a_jog_immediate: assert property ($rose(jogging_o) |-> ##[0:1] freq_monitor_o == jcap)
		else $error("jog frequency ramped");
	a_jog_minimum: assert property (jogging_o |-> jog_frequency_i != 0 && jog_frequency_i >= start_frequency_i)
		else $error("jog below start frequency");
	a_jog_source: assert property ($rose(jogging_o) |-> run_cmd_source_i == RUN_SRC_TERMINAL)
		else $error("jog with keypad source");
	a_jog_runs: assert property (jogging_o |-> running_o)
		else $error("jogging while stopped");
	a_coast_pulse: assert property (coast_o |-> jog_stop_select_i != JOG_STOP_DECEL && jog_stop_select_i != JOG_STOP_DCBRAKE ##1 !coast_o)
		else $error("bad coast pulse");
	a_coast_zero: assert property (coast_o |-> ##[0:2] freq_monitor_o == 16'h0000)
		else $error("coast kept output");
	a_brake_hold: assert property ($rose(dc_brake_o) |-> jog_stop_select_i == JOG_STOP_DCBRAKE ##0 dc_brake_o[*8])
		else $error("bad brake hold");
	a_reject_store: assert property ($rose(store_reject_o) |-> $past(store_key_i))
		else $error("reject without store");
endmodule
`default_nettype wire

// *** verif/test_multispeed_jog_select.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_multispeed_jog_select
	import mspeed_pkg::*;
	;
	logic                        clk_sys_i = 1'b0, rst_i = 1'b1;
	logic [NUM_TERMS-1:0]        term_pin_i;
	logic                        fwd_run_pin_i = 1'b0, rev_run_pin_i = 1'b0;
	// reversed order so terminal 0 carries the top select bit
	logic [NUM_TERMS*CODE_W-1:0] terminal_function_key_i = {FUNCTION_KEY_JOG, FUNCTION_KEY_SEL_BIT0, FUNCTION_KEY_SEL_BIT1,
		FUNCTION_KEY_SEL_BIT2, FUNCTION_KEY_SEL_BIT3};
	logic [CODE_W-1:0]           run_cmd_source_i = RUN_SRC_TERMINAL, jog_stop_select_i = 8'h00;
	logic [FREQ_W-1:0]           jog_frequency_i = 16'h0032, max_frequency_limit_i = 16'h01f4;
	logic [FREQ_W-1:0]           start_frequency_i = 16'h0014, param_data_i = 16'h0000;
	logic                        run_key_i = 1'b0, up_key_i = 1'b0, down_key_i = 1'b0;
	logic                        store_key_i = 1'b0, param_wr_i = 1'b0;
	logic [SEL_W-1:0]            param_idx_i = 4'h0, speed_sel_o, sel_req = 4'h0;
	logic [FREQ_W-1:0]           target_freq_o, freq_monitor_o, freq_setting_display_o;
	logic                        running_o, jogging_o, coast_o, dc_brake_o, store_reject_o;
	logic                        jog_req = 1'b0, seen_coast = 1'b0, seen_brake = 1'b0;
	int                          n_fail = 0, samples_checked = 0;
	typedef struct packed {logic [3:0] what; logic [15:0] val;} note_t;
	note_t                       notes[$];
	event                        chk_ev;

	always #2 clk_sys_i = ~clk_sys_i;
	multispeed_jog_select #(.RAMP_CYC(4)) dut_u (.clk_sys_i, .rst_i, .term_pin_i, .fwd_run_pin_i,
		.rev_run_pin_i, .terminal_function_key_i, .run_cmd_source_i, .jog_frequency_i, .jog_stop_select_i,
		.max_frequency_limit_i, .start_frequency_i, .run_key_i, .up_key_i, .down_key_i, .store_key_i,
		.param_wr_i, .param_idx_i, .param_data_i, .target_freq_o, .freq_monitor_o,
		.freq_setting_display_o, .speed_sel_o, .running_o, .jogging_o, .coast_o, .dc_brake_o,
		.store_reject_o);
	mspeed_partner part_u (.clk_sys_i, .sel_i(sel_req), .jog_i(jog_req), .running_i(running_o),
		.function_key_i(terminal_function_key_i), .pin_o(term_pin_i));

	// ----
	// result watching
	// ----
	task cmp_freq(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task cmp_flag(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask
	task cmp_sel(input string nm, input logic [3:0] e, input logic [3:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// yield so the watcher drains before the stimulus clears latched flags
	task note(input logic [3:0] what, input logic [15:0] val);
		notes.push_back({what, val});
		->chk_ev;
		#0;
	endtask
	// short pulses are latched so a one-cycle coast is not missed
	always @(posedge clk_sys_i)
	begin
		if (coast_o === 1'b1)
			seen_coast = 1'b1;
		if (dc_brake_o === 1'b1)
			seen_brake = 1'b1;
	end
	// oldest note is compared against the outputs as they stand
	initial
	begin
		note_t n;
		forever
		begin
			@(chk_ev);
			while (notes.size() > 0)
			begin
				n = notes.pop_front();
				case (n.what)
					4'd0: cmp_freq("target_freq", n.val, target_freq_o);
					4'd1: cmp_freq("display", n.val, freq_setting_display_o);
					4'd2: cmp_freq("monitor", n.val, freq_monitor_o);
					4'd3: cmp_flag("jogging", n.val[0], jogging_o);
					4'd4: cmp_flag("running", n.val[0], running_o);
					4'd5: cmp_flag("reject", n.val[0], store_reject_o);
					4'd6: cmp_flag("coast_seen", n.val[0], seen_coast);
					4'd8: cmp_sel("speed_sel", n.val[3:0], speed_sel_o);
					default: cmp_flag("brake_seen", n.val[0], seen_brake);
				endcase
			end
		end
	end

	// ----
	// stimulus helpers
	// ----
	task complete_run;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic press(ref logic k);
		k = 1'b1;
		tick(1);
		k = 1'b0;
		tick(1);
	endtask
	// two sync flops plus two registers before the target settles
	task sel(input int i);
		sel_req = i[3:0];
		tick(6);
	endtask
	task kstore(input int i, input logic [15:0] v);
		param_wr_i = 1'b1;
		param_idx_i = i[3:0];
		param_data_i = v;
		store_key_i = 1'b1;
		tick(1);
		param_wr_i = 1'b0;
		store_key_i = 1'b0;
		tick(3);
	endtask
	// bounded: decel and brake hold finish well inside this
	task wait_stop;
		for (int i = 0; running_o !== 1'b0; i++)
		begin
			if (i == 5000)
			begin
				n_fail++;
				complete_run();
			end
			tick(1);
		end
		tick(2);
	endtask

	// ----
	// main sequence
	// ----
	initial
	begin
		logic [15:0] v[16];
		logic [15:0] jf;
		int          i;
		i = $urandom(86);
		tick(12);
		rst_i = 1'b0;
		tick(2);
		for (i = 0; i < 16; i++)
		begin
			v[i] = $urandom % 16'h01e0;
			kstore(i, v[i]);
		end
		for (i = 0; i < 16; i++)
		begin
			sel(i);
			note(4'd0, v[i]);
			note(4'd8, {12'h000, i[3:0]});
		end
		// over-limit store refused, register kept
		sel(5);
		kstore(5, 16'h01f5);
		note(4'd5, 16'h0001);
		note(4'd0, v[5]);
		kstore(5, v[5]);
		note(4'd5, 16'h0000);
		// terminal edit with run off: +4 -1 then store
		sel(6);
		repeat (4) press(up_key_i);
		press(down_key_i);
		press(store_key_i);
		tick(3);
		v[6] = v[6] + 16'h0003;
		note(4'd0, v[6]);
		note(4'd1, v[6]);
		// an edit lost by a select change cannot be stored later
		sel(7);
		press(up_key_i);
		sel(8);
		sel(7);
		press(store_key_i);
		tick(3);
		note(4'd0, v[7]);
		// both run pins together mean stop
		fwd_run_pin_i = 1'b1;
		rev_run_pin_i = 1'b1;
		tick(10);
		note(4'd4, 16'h0000);
		rev_run_pin_i = 1'b0;
		tick(10);
		note(4'd4, 16'h0001);
		fwd_run_pin_i = 1'b0;
		wait_stop();
		// every jog stop code, one setting above the cap
		jog_req = 1'b1;
		tick(6);
		for (i = 0; i < 3; i++)
		begin
			jf = (i == 1) ? 16'h00c8 : 16'h0014 + $urandom % 16'h0050;
			jog_frequency_i = jf;
			jog_stop_select_i = i[7:0];
			seen_coast = 1'b0;
			seen_brake = 1'b0;
			run_key_i = 1'b1;
			tick(8);
			jf = (jf > JOG_LIMIT) ? JOG_LIMIT : jf;
			note(4'd3, 16'h0001);
			note(4'd0, jf);
			note(4'd2, jf);
			run_key_i = 1'b0;
			wait_stop();
			note(4'd6, {15'h0000, i == 0});
			note(4'd7, {15'h0000, i == 2});
			note(4'd2, 16'h0000);
		end
		// refused jogs: zero, below start, keypad source
		for (i = 0; i < 3; i++)
		begin
			jog_frequency_i = (i == 0) ? 16'h0000 : (i == 1) ? 16'h000a : 16'h0032;
			run_cmd_source_i = (i == 2) ? 8'h00 : RUN_SRC_TERMINAL;
			run_key_i = 1'b1;
			tick(8);
			note(4'd3, 16'h0000);
			run_key_i = 1'b0;
			wait_stop();
		end
		complete_run();
	end
endmodule
bind multispeed_jog_select multispeed_jog_select_checker chk_u (.clk_sys_i, .rst_i, .run_cmd_source_i,
	.jog_frequency_i, .jog_stop_select_i, .start_frequency_i, .store_key_i, .target_freq_o,
	.freq_monitor_o, .running_o, .jogging_o, .coast_o, .dc_brake_o, .store_reject_o);
`default_nettype wire
